// file: design/tslr_top.sv
// Serial register file and alert logic of the temperature sensor
`timescale 1ns/100ps
module tslr_top
  import tslr_pkg::*;
#(
  parameter logic [4:0] MAKER_ID    = 5'h0a,  // Arbitrary value
  parameter logic [2:0] SILICON_REV = 3'h1    // Arbitrary value
)(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  output      logic        dout,
  output      logic        dout_oe,
  input  wire logic [15:0] conv_temp,
  input  wire logic        conv_valid,
  output      logic        critical_alert_out,
  output      logic        limit_alert_out
);
  tslr_state_t r_r;
  tslr_state_t r_nxt;
  tslr_pins_t  pin_s;
  logic        rise;
  logic        fall;
  logic [15:0] tcmp;
  logic [15:0] res_w;
  logic        crit_nxt;
  logic        high_nxt;
  logic        low_nxt;
  logic        rd_hit;
  logic        wr_hit;
  logic [15:0] wr_word;

  tslr_sync #(
    .W       ($bits(tslr_pins_t)),
    .RST_VAL (PINS_IDLE)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d       ({sclk, cs_n, din}),
    .q       (pin_s)
  );

  // Edges of the host clock, seen after synchronisation
  assign rise = pin_s.sclk & ~r_r.sclk_d;
  assign fall = ~pin_s.sclk & r_r.sclk_d;

  // Flag bits are dropped from the compared value in 13-bit mode
  assign tcmp = r_r.cfg[CFG_RES_BIT] ? r_r.temp : {r_r.temp[15:3], 3'h0};

  // Result word as read back
  assign res_w = r_r.cfg[CFG_RES_BIT] ? r_r.temp :
                 {r_r.temp[15:3], r_r.crit_st, r_r.high_st, r_r.low_st};

  tslr_cmp u_cmp_crit (
    .temp   (tcmp),
    .limit  (r_r.crit),
    .hyst   (r_r.hyst[3:0]),
    .over   (1'b1),
    .cur_st (r_r.crit_st),
    .nxt_st (crit_nxt)
  );

  tslr_cmp u_cmp_high (
    .temp   (tcmp),
    .limit  (r_r.high),
    .hyst   (r_r.hyst[3:0]),
    .over   (1'b1),
    .cur_st (r_r.high_st),
    .nxt_st (high_nxt)
  );

  tslr_cmp u_cmp_low (
    .temp   (tcmp),
    .limit  (r_r.low),
    .hyst   (r_r.hyst[3:0]),
    .over   (1'b0),
    .cur_st (r_r.low_st),
    .nxt_st (low_nxt)
  );

  function automatic logic is_wide(input logic [2:0] a);
    return (a == ADDR_TEMP) || (a == ADDR_CRIT) || (a == ADDR_HIGH) || (a == ADDR_LOW);
  endfunction

  // Read data, MSB aligned so the first bit out is bit 15
  function automatic logic [15:0] rd_word(input logic [2:0] a, input tslr_state_t s, input logic [15:0] res);
    logic [15:0] w;
    w = 16'h0000;
    case (a)
      ADDR_CFG:  w = {s.cfg, 8'h00};
      ADDR_TEMP: w = res;
      ADDR_ID:   w = {MAKER_ID, SILICON_REV, 8'h00};
      ADDR_CRIT: w = s.crit;
      ADDR_HYST: w = {s.hyst, 8'h00};
      ADDR_HIGH: w = s.high;
      ADDR_LOW:  w = s.low;
      default:   w = 16'h0000;
    endcase
    return w;
  endfunction

  always_comb
  begin
    r_nxt        = r_r;
    r_nxt.sclk_d = pin_s.sclk;
    r_nxt.eval   = 1'b0;
    rd_hit       = 1'b0;
    wr_hit       = 1'b0;
    wr_word      = {r_r.sh_in[14:0], pin_s.din};

    // Select low gates the whole serial port
    if (pin_s.cs_n)
    begin
      r_nxt.st      = ST_IDLE;
      r_nxt.cnt     = 5'h00;
      r_nxt.dout_oe = 1'b0;
    end
    else
    begin
      r_nxt.dout_oe = 1'b1;
      case (r_r.st)
        ST_IDLE, ST_CMD:
        begin
          r_nxt.st = ST_CMD;
          if (rise)
          begin
            r_nxt.sh_in = wr_word;
            r_nxt.cnt   = r_r.cnt + 5'h01;
            if (r_r.cnt == LAST_BYTE)
            begin
              // Address taken from the command byte
              r_nxt.cmd    = wr_word[7:0];
              r_nxt.cnt    = 5'h00;
              r_nxt.st     = ST_DATA;
              r_nxt.sh_out = rd_word(wr_word[CMD_ADDR_MSB:CMD_ADDR_LSB], r_r, res_w);
              rd_hit       = wr_word[CMD_RD_BIT];
            end
          end
        end
        ST_DATA:
        begin
          if (rise)
          begin
            r_nxt.sh_in = wr_word;
            r_nxt.cnt   = r_r.cnt + 5'h01;
            if (r_r.cnt == (is_wide(r_r.cmd[CMD_ADDR_MSB:CMD_ADDR_LSB]) ? LAST_WORD : LAST_BYTE))
            begin
              r_nxt.st = ST_DONE;
              wr_hit   = !r_r.cmd[CMD_RD_BIT];
            end
          end
          if (fall && r_r.cmd[CMD_RD_BIT])
          begin
            r_nxt.dout   = r_r.sh_out[15];
            r_nxt.sh_out = {r_r.sh_out[14:0], 1'b0};
          end
        end
        ST_DONE:
        begin
          if (fall && r_r.cmd[CMD_RD_BIT])
          begin
            r_nxt.dout   = r_r.sh_out[15];
            r_nxt.sh_out = {r_r.sh_out[14:0], 1'b0};
          end
        end
        default:
          r_nxt.st = ST_IDLE;
      endcase
    end

    // Register writes; read-only addresses ignore the data
    if (wr_hit)
    begin
      case (r_r.cmd[CMD_ADDR_MSB:CMD_ADDR_LSB])
        ADDR_CFG:  r_nxt.cfg  = wr_word[7:0];
        ADDR_CRIT: r_nxt.crit = wr_word;
        ADDR_HYST: r_nxt.hyst = wr_word[7:0];
        ADDR_HIGH: r_nxt.high = wr_word;
        ADDR_LOW:  r_nxt.low  = wr_word;
        default:   r_nxt.cfg  = r_r.cfg;
      endcase
    end

    // Any register read clears the latched alerts
    if (rd_hit)
    begin
      r_nxt.crit_lat = 1'b0;
      r_nxt.lim_lat  = 1'b0;
    end

    // New conversion result, compared one cycle later
    if (conv_valid)
    begin
      r_nxt.temp = conv_temp;
      r_nxt.eval = 1'b1;
    end

    if (r_r.eval)
    begin
      r_nxt.crit_st = crit_nxt;
      r_nxt.high_st = high_nxt;
      r_nxt.low_st  = low_nxt;
      // New events set the latches after any clear, so set wins
      if (crit_nxt && !r_r.crit_st)
        r_nxt.crit_lat = 1'b1;
      if ((high_nxt && !r_r.high_st) || (low_nxt && !r_r.low_st))
        r_nxt.lim_lat = 1'b1;
    end

    // Mode and polarity of both alert outputs
    r_nxt.crit_o = ~((r_nxt.cfg[CFG_CMP_BIT] ? r_nxt.crit_st : r_nxt.crit_lat) ^ r_nxt.cfg[CFG_CRIT_POL]);
    r_nxt.lim_o  = ~((r_nxt.cfg[CFG_CMP_BIT] ? (r_nxt.high_st | r_nxt.low_st) : r_nxt.lim_lat)
                     ^ r_nxt.cfg[CFG_LIM_POL]);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      r_r        <= '0;
      r_r.sclk_d <= PINS_IDLE.sclk;
      r_r.temp   <= TEMP_RST;
      r_r.cfg    <= CFG_RST;
      r_r.crit   <= CRIT_RST;
      r_r.hyst   <= HYST_RST;
      r_r.high   <= HIGH_RST;
      r_r.low    <= LOW_RST;
      r_r.crit_o <= 1'b1;
      r_r.lim_o  <= 1'b1;
    end
    else
      r_r <= r_nxt;
  end

  assign dout               = r_r.dout;
  assign dout_oe            = r_r.dout_oe;
  assign critical_alert_out = r_r.crit_o;
  assign limit_alert_out    = r_r.lim_o;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  temp_store_a: assert property (r_r.eval |-> r_r.temp == $past(conv_temp))
    else $error("stored temperature differs from conversion");
  flag_bits_a: assert property (!r_r.cfg[CFG_RES_BIT] |-> res_w[2:0] == {r_r.crit_st, r_r.high_st, r_r.low_st})
    else $error("result flags do not follow alarm states");
  ext_bits_a: assert property (r_r.cfg[CFG_RES_BIT] |-> res_w == r_r.temp)
    else $error("16-bit result not passed through");
  temp_ro_a: assert property (!$past(conv_valid) |-> $stable(r_r.temp))
    else $error("temperature changed without a conversion");
  crit_trip_a: assert property (r_r.eval && $signed(tcmp) > $signed(r_r.crit) |=> r_r.crit_st)
    else $error("critical state not set above limit");
  high_trip_a: assert property (r_r.eval && $signed(tcmp) > $signed(r_r.high) |=> r_r.high_st)
    else $error("high state not set above limit");
  low_trip_a: assert property (r_r.eval && $signed(tcmp) < $signed(r_r.low) |=> r_r.low_st)
    else $error("low state not set below limit");
  cmp_mode_a: assert property (r_r.cfg[CFG_CMP_BIT] |-> critical_alert_out == ~(r_r.crit_st ^ r_r.cfg[CFG_CRIT_POL]))
    else $error("comparator mode critical output wrong");
  dout_edge_a: assert property ($changed(dout) |-> $past(fall))
    else $error("serial output changed off a falling edge");
  hyst_keep_a: assert property (r_r.eval && r_r.high_st && $signed({tcmp[15], tcmp}) >=
                                $signed({r_r.high[15], r_r.high}) - $signed({6'h00, r_r.hyst[3:0], 7'h00})
                                |=> r_r.high_st)
    else $error("high state released inside hysteresis band");

  // Sign-extended views used by the band assertions
  logic signed [16:0] t_x;
  logic signed [16:0] crit_x;
  logic signed [16:0] low_x;
  logic signed [16:0] band_x;

  assign t_x    = {tcmp[15], tcmp};
  assign crit_x = {r_r.crit[15], r_r.crit};
  assign low_x  = {r_r.low[15], r_r.low};
  assign band_x = signed'({13'h0000, r_r.hyst[3:0]} << HYST_SHIFT);

  // Select gating, hysteresis band, alert latches and register writes
  oe_select_a: assert property (pin_s.cs_n |=> !dout_oe)
    else $error("serial output driven while deselected");
  crit_keep_a: assert property (r_r.eval && r_r.crit_st && t_x >= crit_x - band_x |=> r_r.crit_st)
    else $error("critical state released inside hysteresis band");
  crit_rel_a: assert property (r_r.eval && r_r.crit_st && t_x < crit_x - band_x |=> !r_r.crit_st)
    else $error("critical state held below hysteresis band");
  low_keep_a: assert property (r_r.eval && r_r.low_st && t_x <= low_x + band_x |=> r_r.low_st)
    else $error("low state released inside hysteresis band");
  low_rel_a: assert property (r_r.eval && r_r.low_st && t_x > low_x + band_x |=> !r_r.low_st)
    else $error("low state held above hysteresis band");
  lat_set_a: assert property (r_r.eval && !r_r.crit_st && t_x > crit_x |=> r_r.crit_lat)
    else $error("critical event not latched");
  rd_clear_a: assert property (rd_hit && !r_r.eval |=> !r_r.crit_lat && !r_r.lim_lat)
    else $error("register read did not clear alert latches");
  int_mode_a: assert property (!r_r.cfg[CFG_CMP_BIT] |->
                               limit_alert_out == ~(r_r.lim_lat ^ r_r.cfg[CFG_LIM_POL]))
    else $error("interrupt mode limit output wrong");
  lim_cmp_a: assert property (r_r.cfg[CFG_CMP_BIT] |->
                              limit_alert_out == ~((r_r.high_st | r_r.low_st) ^ r_r.cfg[CFG_LIM_POL]))
    else $error("comparator mode limit output wrong");
  high_write_a: assert property (wr_hit && r_r.cmd[CMD_ADDR_MSB:CMD_ADDR_LSB] == ADDR_HIGH |=>
                                 r_r.high == $past(wr_word))
    else $error("high limit write not stored");
  cfg_keep_a: assert property (wr_hit && r_r.cmd[CMD_ADDR_MSB:CMD_ADDR_LSB] != ADDR_CFG |=>
                               $stable(r_r.cfg))
    else $error("configuration changed by another register write");
endmodule

// file: design/tslr_pkg.sv
// Constants and types for the temperature sensor limit register block
// Behaviour
// - Result register holds 16-bit signed temperature
// - 13-bit mode: bits 2..0 are alarm flags
// - 16-bit mode: bits 2..0 are extension bits
// - Bits 15..3 read-only temperature, reset zero
// - Read-only ID: maker and revision
// - Critical alert when temperature exceeds critical limit
// - Critical limit read/write, resets to 0x4980
// - Hysteresis register, four low bits, degrees
// - Hysteresis moves limits toward release side
// - Hysteresis resets to five, upper bits zero
// - Limit alert when temperature above high limit
// - High limit read/write, resets to 0x2000
// - Limit alert when temperature below low limit
// - Low limit read/write, resets to 0x0500
// - Serial port: din, dout, sclk, select low
// - Sample on rising, drive on falling edge
// - Config bit 7 selects 13/16-bit resolution
// - Config bit 4: latched or comparator alerts
// - Config bits 2/3 set alert polarities
package tslr_pkg;

  localparam logic [2:0]  ADDR_CFG      = 3'h1;
  localparam logic [2:0]  ADDR_TEMP     = 3'h2;
  localparam logic [2:0]  ADDR_ID       = 3'h3;
  localparam logic [2:0]  ADDR_CRIT     = 3'h4;
  localparam logic [2:0]  ADDR_HYST     = 3'h5;
  localparam logic [2:0]  ADDR_HIGH     = 3'h6;
  localparam logic [2:0]  ADDR_LOW      = 3'h7;

  localparam int          CMD_RD_BIT    = 6;
  localparam int          CMD_ADDR_MSB  = 5;
  localparam int          CMD_ADDR_LSB  = 3;
  localparam logic [4:0]  LAST_BYTE     = 5'h07;
  localparam logic [4:0]  LAST_WORD     = 5'h0f;

  localparam int          CFG_RES_BIT   = 7;
  localparam int          CFG_CMP_BIT   = 4;
  localparam int          CFG_LIM_POL   = 3;
  localparam int          CFG_CRIT_POL  = 2;

  localparam int          FLAG_CRIT_BIT = 2;
  localparam int          FLAG_HIGH_BIT = 1;
  localparam int          FLAG_LOW_BIT  = 0;

  localparam logic [15:0] TEMP_RST      = 16'h0000;
  localparam logic [7:0]  CFG_RST       = 8'h00;
  localparam logic [15:0] CRIT_RST      = 16'h4980;
  localparam logic [7:0]  HYST_RST      = 8'h05;
  localparam logic [15:0] HIGH_RST      = 16'h2000;
  localparam logic [15:0] LOW_RST       = 16'h0500;

  // One degree is 128 counts of the 16-bit result word
  localparam int          HYST_SHIFT    = 7;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD  = 2'b01,
    ST_DATA = 2'b11,
    ST_DONE = 2'b10
  } tslr_st_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic din;
  } tslr_pins_t;

  // Idle levels of the host pins: clock high, deselected
  localparam tslr_pins_t PINS_IDLE = '{sclk: 1'b1, cs_n: 1'b1, din: 1'b0};

  typedef struct packed {
    tslr_st_t    st;
    logic [4:0]  cnt;
    logic [7:0]  cmd;
    logic [15:0] sh_in;
    logic [15:0] sh_out;
    logic        sclk_d;
    logic [15:0] temp;
    logic [7:0]  cfg;
    logic [15:0] crit;
    logic [7:0]  hyst;
    logic [15:0] high;
    logic [15:0] low;
    logic        crit_st;
    logic        high_st;
    logic        low_st;
    logic        crit_lat;
    logic        lim_lat;
    logic        eval;
    logic        dout;
    logic        dout_oe;
    logic        crit_o;
    logic        lim_o;
  } tslr_state_t;

endpackage

// file: design/tslr_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module tslr_sync
  import tslr_pkg::*;
#(
  parameter int           W       = 3,
  parameter logic [W-1:0] RST_VAL = '0
)(
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output      logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tslr_sync_t;

  tslr_sync_t r_r;
  tslr_sync_t r_nxt;

  if (W < 1)
  begin : g_chk
    $error("tslr_sync width must be at least one");
  end

  always_comb
  begin
    r_nxt    = r_r;
    r_nxt.s1 = d;
    r_nxt.s2 = r_r.s1;
  end

  always_ff @(posedge ref_clk)
  begin
    // Reset to the idle levels so no false edge or select follows reset
    if (!rst_n)
      r_r <= '{s1: RST_VAL, s2: RST_VAL};
    else
      r_r <= r_nxt;
  end

  assign q = r_r.s2;
endmodule

// file: design/tslr_cmp.sv
// Limit comparator with hysteresis on the release side
`timescale 1ns/100ps
module tslr_cmp
  import tslr_pkg::*;
(
  input  wire logic [15:0] temp,
  input  wire logic [15:0] limit,
  input  wire logic [3:0]  hyst,
  input  wire logic        over,
  input  wire logic        cur_st,
  output      logic        nxt_st
);
  logic signed [16:0] t_s;
  logic signed [16:0] l_s;
  logic signed [16:0] h_s;
  logic               trip;
  logic               rel;

  always_comb
  begin
    t_s = {temp[15], temp};
    l_s = {limit[15], limit};
    h_s = signed'({13'h0000, hyst} << HYST_SHIFT);
    // Signed compare, released past the hysteresis band
    if (over)
    begin
      trip = t_s > l_s;
      rel  = t_s < (l_s - h_s);
    end
    else
    begin
      trip = t_s < l_s;
      rel  = t_s > (l_s + h_s);
    end
    nxt_st = cur_st ? !rel : trip;
  end
endmodule

// file: dv/tslr_host.sv
// Host side serial master model for the sensor register port
`timescale 1ns/100ps
module tslr_host
  import tslr_pkg::*;
(
  input  wire logic ref_clk,
  output      logic sclk,
  output      logic cs_n,
  output      logic din,
  input  wire logic dout
);
  // Half serial period in ref_clk cycles, giving an 80 ns link clock
  localparam int HALF = 8;

  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // One frame: command byte, then nbits of data, MSB first on both lines
  task automatic xfer(input logic [7:0] cmd, input int nbits, input logic [15:0] wdata,
                      output logic [15:0] rdata);
    logic [23:0] sh;
    sh    = {cmd, wdata << (16 - nbits)};
    rdata = 16'h0000;
    tick(1);
    cs_n = 1'b0;
    tick(HALF);
    for (int i = 0; i < 8 + nbits; i++)
    begin
      sclk = 1'b0;
      din  = sh[23 - i];
      tick(HALF);
      if (i >= 8)
        rdata = {rdata[14:0], dout};
      sclk = 1'b1;
      tick(HALF);
    end
    cs_n = 1'b1;
    // Released line must not keep showing the last bit
    din  = ~din;
    tick(HALF);
  endtask
endmodule

// file: dv/tb.sv
// Self-checking bench for the sensor register and alert block
`timescale 1ns/100ps
module tb
  import tslr_pkg::*;
;
  // Arbitrary identification values
  localparam logic [4:0] MK  = 5'h0b;
  localparam logic [2:0] REV = 3'h2;

  logic        ref_clk    = 1'b0;
  logic        rst_n      = 1'b0;
  logic        sclk;
  logic        cs_n;
  logic        din;
  logic        dout;
  logic        dout_oe;
  logic [15:0] conv_temp  = 16'h0000;
  logic        conv_valid = 1'b0;
  logic        crit_al;
  logic        lim_al;
  logic [15:0] rd_v;
  int          fails      = 0;
  int          checks     = 0;

  always #2.5 ref_clk = ~ref_clk;

  tslr_top #(
    .MAKER_ID    (MK),
    .SILICON_REV (REV)
  ) dut_u (
    .ref_clk            (ref_clk),
    .rst_n              (rst_n),
    .sclk               (sclk),
    .cs_n               (cs_n),
    .din                (din),
    .dout               (dout),
    .dout_oe            (dout_oe),
    .conv_temp          (conv_temp),
    .conv_valid         (conv_valid),
    .critical_alert_out (crit_al),
    .limit_alert_out    (lim_al)
  );

  tslr_host host_u (
    .ref_clk (ref_clk),
    .sclk    (sclk),
    .cs_n    (cs_n),
    .din     (din),
    .dout    (dout)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic int nb(input logic [2:0] a);
    return (a inside {ADDR_CFG, ADDR_ID, ADDR_HYST}) ? 8 : 16;
  endfunction

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    host_u.xfer({2'b00, a, 3'b000}, nb(a), d, rd_v);
  endtask

  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    host_u.xfer({2'b01, a, 3'b000}, nb(a), 16'h0000, rd_v);
    chk(rd_v, exp);
  endtask

  // New conversion word, then time for flags and alert outputs to settle
  task automatic conv(input logic [15:0] t);
    conv_temp  = t;
    conv_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    conv_valid = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  task automatic al(input logic c, input logic l);
    chk({14'h0000, crit_al, lim_al}, {14'h0000, c, l});
  endtask

  task automatic conclude();
    $display("Mismatches %0d, checks %0d", fails, checks);
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #300000;
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    conclude();
  end

  initial
  begin
    logic [2:0]  ra [7] = '{ADDR_CFG, ADDR_TEMP, ADDR_ID, ADDR_CRIT, ADDR_HYST, ADDR_HIGH, ADDR_LOW};
    logic [15:0] rv [7] = '{16'h0000, 16'h0000, {8'h00, MK, REV}, 16'h4980, 16'h0005, 16'h2000, 16'h0500};
    repeat (8) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    repeat (3)
    begin
      @(posedge ref_clk);
      #1;
      chk({15'h0000, dout_oe}, 16'h0000);
    end
    al(1'b1, 1'b1);
    foreach (ra[i])
      rd(ra[i], rv[i]);
    // Comparator mode, 13-bit, active-low alerts
    wr(ADDR_CFG, 16'h0010);
    wr(ADDR_CRIT, 16'h3000);
    rd(ADDR_CRIT, 16'h3000);
    wr(ADDR_TEMP, 16'h1234);
    wr(ADDR_ID, 16'h00ff);
    rd(ADDR_TEMP, 16'h0000);
    rd(ADDR_ID, {8'h00, MK, REV});
    conv(16'h3108);
    al(1'b0, 1'b0);
    rd(ADDR_TEMP, 16'h310e);
    conv(16'h2e00);
    al(1'b0, 1'b0);
    conv(16'h1e00);
    al(1'b1, 1'b0);
    conv(16'h1d00);
    al(1'b1, 1'b1);
    conv(16'hf000);
    al(1'b1, 1'b0);
    rd(ADDR_TEMP, 16'hf001);
    conv(16'h0600);
    al(1'b1, 1'b0);
    conv(16'h0800);
    al(1'b1, 1'b1);
    wr(ADDR_HYST, 16'h000f);
    rd(ADDR_HYST, 16'h000f);
    conv(16'h2100);
    conv(16'h1900);
    al(1'b1, 1'b0);
    conv(16'h1800);
    al(1'b1, 1'b1);
    // 16-bit mode: low bits carry data, not flags
    wr(ADDR_CFG, 16'h0090);
    conv(16'h2005);
    rd(ADDR_TEMP, 16'h2005);
    al(1'b1, 1'b0);
    conv(16'h1000);
    // Active-high polarity on both alerts
    wr(ADDR_CFG, 16'h001c);
    conv(16'h3100);
    al(1'b1, 1'b1);
    conv(16'h1000);
    al(1'b0, 1'b0);
    // Interrupt mode: alerts hold until a read
    wr(ADDR_CFG, 16'h0000);
    rd(ADDR_CFG, 16'h0000);
    al(1'b1, 1'b1);
    conv(16'h3100);
    al(1'b0, 1'b0);
    conv(16'h1000);
    al(1'b0, 1'b0);
    rd(ADDR_TEMP, 16'h1000);
    al(1'b1, 1'b1);
    wr(ADDR_LOW, 16'h8000);
    rd(ADDR_LOW, 16'h8000);
    wr(ADDR_HIGH, 16'h7ff8);
    rd(ADDR_HIGH, 16'h7ff8);
    conclude();
  end
endmodule
